//--- slic_cfg.svh
// constants of the status indicator controller
// How it works
// - power LED steady green when on, green code 3 in auto standby.
// - transfer LED yellow while data moves, dark otherwise.
// - fault_indicator steady red while booting or after failed boot.
// - fault_indicator red code 1 during firmware update or logged fault.
// - overheated, stopped, in standby: temperature LED red code 3.
// - overheated, stopped, no standby: temperature LED steady red.
// - critical temperature reached: temperature LED red code 2.
// - temperature LED dark in normal temperature range.
// - model LED yellow code 1 from RAM, code 3 from flash, else dark.
// - driver LED green code 1 with realtime_io_driver enabled, code 3 without, dark with no model.
// - sync master without external sync: blue flash, full brightness only.
// - sync slave: blue flash alternating half and full brightness.
// - interface LEDs show states only while unit is fully on.
// - shared CAN/LIN traffic LED yellow if any of four channels talks.
// - probe traffic LED yellow while communicating, dark when interrupted.
// - daisy chain: traffic yellow; state red on error, 1 Hz config, else dark.
// - fieldbus state LED: dark, slow blink, single flash, steady, flicker.
// - fieldbus mode: port traffic LED yellow while communicating.
// - beeper short beeps at critical temperature, continuous tone once exceeded.
`ifndef SLIC_CFG_SVH
`define SLIC_CFG_SVH

// register byte offsets
`define SLIC_OFF_CTRL   8'h00
`define SLIC_OFF_CFG    8'h04
`define SLIC_OFF_STAT   8'h08
`define SLIC_OFF_LEDS   8'h0C
`define SLIC_CTRL_RST   32'h0000_0000
`define SLIC_CFG_RST    32'h0000_0000
`define SLIC_RESP_OK    2'h0
`define SLIC_RESP_ERR   2'h2

// pattern timing: one tick is the smallest blink step
`define SLIC_CLK_HZ       25000000
`define SLIC_TICK_MS      50
`define SLIC_TICK_CYCLES  ((`SLIC_CLK_HZ / 1000) * `SLIC_TICK_MS)
`define SLIC_FRAME_TICKS  6'h28
`define SLIC_PULSE_TICKS  6'h04
`define SLIC_HZ1_TICKS    6'h0A
`define SLIC_SYNC_PERIOD  6'h10
`define SLIC_SYNC_HALF    6'h08

`endif

//--- slic_chk.sv
// assertion checker of the status indicator controller
`timescale 1ns/1ps
module slic_chk (
    input wire logic                i_clk_sys,
    input wire logic                i_resetn,
    input wire logic                i_ce,
    input wire slic_pkg::slic_act_t i_act,
    input wire logic                i_awvalid,
    input wire logic                o_awready,
    input wire logic                i_wvalid,
    input wire logic                o_wready,
    input wire logic [1:0]          o_bresp,
    input wire logic                o_bvalid,
    input wire logic                i_bready,
    input wire logic                i_arvalid,
    input wire logic                o_arready,
    input wire logic [31:0]         o_rdata,
    input wire logic                o_rvalid,
    input wire logic                i_rready,
    input wire slic_pkg::slic_led_t o_led,
    input wire logic                o_beep
);
    import slic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // one domain, all checks idle during reset except reset_quiet_a
    default clocking dclk @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    // bus take steps; activity needs 4 edges to pass sync and output flop
    sequence wr_take_s;
        i_ce && i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence rd_take_s;
        i_ce && i_arvalid && o_arready;
    endsequence
    sequence bus_quiet_s;
        (i_ce && i_act.can == 2'h0 && i_act.lin == 2'h0) [*4];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before bready");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before rready");
    wr_answer_a: assert property (wr_take_s |-> ##2 o_bvalid)
        else $error("write response not on time");
    rd_answer_a: assert property (rd_take_s |=> o_rvalid)
        else $error("read data not on time");
    tx_follow_a: assert property (
        (i_ce && $stable(i_act.transfer)) [*4] |-> o_led.tx_yellow == i_act.transfer)
        else $error("transfer lamp does not follow activity");
    bus_dark_a: assert property (bus_quiet_s |-> !o_led.bus_yellow)
        else $error("shared bus lamp lit with all channels silent");
    probe_dark_a: assert property ((i_ce && !i_act.probe) [*4] |-> !o_led.probe_yellow)
        else $error("probe lamp lit without traffic");
    eth_dark_a: assert property (
        (i_ce && !i_act.eth_link[0]) [*4] |->
        (o_led.eth_t_yellow[0] | o_led.eth_s_green[0] | o_led.eth_s_yellow[0]) == 1'b0)
        else $error("ethernet lamps lit without link");
    reset_quiet_a: assert property (disable iff (1'b0)
        !i_resetn |-> o_led == '0 && !o_beep && !o_bvalid && !o_rvalid)
        else $error("outputs active during reset");
endmodule : slic_chk

bind slic_top slic_chk u_slic_chk (.*);

//--- slic_panel.sv
// operator panel model: counts lit cycles and flashes of one lamp
`timescale 1ns/1ps
module slic_panel (
    input  wire logic                i_clk_sys,
    input  wire logic                i_clr,
    input  wire logic [4:0]          i_sel,
    input  wire slic_pkg::slic_led_t i_led,
    input  wire logic                i_beep,
    output logic [7:0]               o_on,
    output logic [7:0]               o_rise
);
    import slic_pkg::*;
    logic [$bits(slic_led_t):0] lamp_q;
    logic [$bits(slic_led_t):0] lamp;

    ////////////////////////////////////////////////////////////////////////////////
    // beeper sits at bit 0 so it is watched like any lamp
    assign lamp = {i_led, i_beep};
    // half brightness is seen as toggling, so it counts as many flashes
    always_ff @(posedge i_clk_sys)
    begin
        lamp_q <= lamp;
        o_on   <= i_clr ? 8'h00 : o_on + 8'(lamp[i_sel]);
        o_rise <= i_clr ? 8'h00 : o_rise + 8'(lamp[i_sel] & ~lamp_q[i_sel]);
    end
endmodule : slic_panel

//--- slic_pkg.sv
// types of the status indicator controller
package slic_pkg;

    typedef enum logic [1:0] {PWR_OFF, PWR_STANDBY, PWR_ON} slic_pwr_t;
    typedef enum logic [1:0] {BOOT_DONE, BOOT_BUSY, BOOT_FAILED} slic_boot_t;
    typedef enum logic [1:0] {MODEL_NONE, MODEL_RAM, MODEL_FLASH} slic_model_t;
    typedef enum logic [1:0] {TEMP_NORMAL, TEMP_REACHED, TEMP_OVER_STOP, TEMP_OVER_STBY} slic_temp_t;
    typedef enum logic [1:0] {CHAIN_OK, CHAIN_ERR, CHAIN_CONFIG} slic_chain_t;
    typedef enum logic [2:0] {FB_INIT, FB_PREOP, FB_SAFEOP, FB_OP, FB_BOOT} slic_fb_t;

    // software control word
    typedef struct packed {
        logic [20:0] rsvd;
        logic        sync_slave;
        logic        sync_master;
        logic        realtime_io_driver;
        slic_model_t model;
        logic        fw_update;
        slic_boot_t  boot;
        logic        auto_power;
        slic_pwr_t   power;
    } slic_ctrl_t;

    // software configuration word
    typedef struct packed {
        logic [21:0] rsvd;
        logic [1:0]  eth_gig;
        slic_fb_t    fb_state;
        slic_chain_t chain;
        logic        io_fieldbus;
        slic_temp_t  temp;
    } slic_cfg_t;

    // activity levels from the interfaces
    typedef struct packed {
        logic       transfer;
        logic [1:0] can;
        logic [1:0] lin;
        logic       probe;
        logic       io;
        logic [1:0] eth_act;
        logic [1:0] eth_link;
    } slic_act_t;

    // LED drive bits, one per colour element
    typedef struct packed {
        logic       pwr_green;
        logic       tx_yellow;
        logic       fault_red;
        logic       temp_red;
        logic       model_yellow;
        logic       drv_green;
        logic       sync_blue;
        logic       bus_yellow;
        logic       probe_yellow;
        logic       io_yellow;
        logic       io_red;
        logic [1:0] eth_t_yellow;
        logic [1:0] eth_s_green;
        logic [1:0] eth_s_yellow;
    } slic_led_t;

endpackage : slic_pkg

//--- slic_top.sv
// status indicator controller with AXI4-Lite registers
`timescale 1ns/1ps
`include "slic_cfg.svh"

module slic_top #(
    parameter int unsigned TICK_CYCLES = `SLIC_TICK_CYCLES,
    parameter int unsigned ADDR_W      = 8
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_resetn,
    input  wire logic               i_ce,
    input  wire slic_pkg::slic_act_t i_act,
    input  wire logic               i_fault_evt,
    input  wire logic [ADDR_W-1:0]  i_awaddr,
    input  wire logic               i_awvalid,
    output logic                    o_awready,
    input  wire logic [31:0]        i_wdata,
    input  wire logic [3:0]         i_wstrb,
    input  wire logic               i_wvalid,
    output logic                    o_wready,
    output logic [1:0]              o_bresp,
    output logic                    o_bvalid,
    input  wire logic               i_bready,
    input  wire logic [ADDR_W-1:0]  i_araddr,
    input  wire logic               i_arvalid,
    output logic                    o_arready,
    output logic [31:0]             o_rdata,
    output logic [1:0]              o_rresp,
    output logic                    o_rvalid,
    input  wire logic               i_rready,
    output slic_pkg::slic_led_t     o_led,
    output logic                    o_beep
);
    import slic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // register map decode, shared by read and write paths
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == ADDR_W'(`SLIC_OFF_CTRL)) || (a == ADDR_W'(`SLIC_OFF_CFG))
               || (a == ADDR_W'(`SLIC_OFF_STAT)) || (a == ADDR_W'(`SLIC_OFF_LEDS));
    endfunction : addr_ok

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = old;
        for (int b = 0; b < 4; b++)
            if (s[b])
                merge[b*8 +: 8] = d[b*8 +: 8];
    endfunction : merge

    // flash code n: n pulses of one pulse time, spaced by one pulse time
    function automatic logic flash_code(input logic [5:0] idx, input logic [2:0] n);
        logic [5:0] len;
        len = 6'({3'h0, n} * (`SLIC_PULSE_TICKS * 6'h02));
        flash_code = (idx < len) && ((idx % (`SLIC_PULSE_TICKS * 6'h02)) < `SLIC_PULSE_TICKS);
    endfunction : flash_code

    ////////////////////////////////////////////////////////////////////////////
    // activity synchroniser: pins come from foreign clocks

    slic_act_t act_s1_q;
    slic_act_t act_s2_q;

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            act_s1_q <= '0;
            act_s2_q <= '0;
        end
        else if (i_ce)
        begin
            act_s1_q <= i_act;
            act_s2_q <= act_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pattern time base

    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    logic [TW-1:0] tick_cnt_q, tick_cnt_d;
    logic [5:0]    idx_q, idx_d;
    logic          pwm_q, pwm_d;

    // tick prescaler and frame index; pwm halves brightness
    always_comb
    begin
        tick_cnt_d = tick_cnt_q + TW'(1);
        idx_d      = idx_q;
        pwm_d      = ~pwm_q;
        if (tick_cnt_q == TW'(TICK_CYCLES - 1))
        begin
            tick_cnt_d = '0;
            idx_d      = (idx_q == `SLIC_FRAME_TICKS - 6'h01) ? 6'h00 : idx_q + 6'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            tick_cnt_q <= '0;
            idx_q      <= 6'h00;
            pwm_q      <= 1'b0;
        end
        else if (i_ce)
        begin
            tick_cnt_q <= tick_cnt_d;
            idx_q      <= idx_d;
            pwm_q      <= pwm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave and register file

    slic_ctrl_t        ctrl_q, ctrl_d;
    slic_cfg_t         cfg_q, cfg_d;
    logic              fault_q, fault_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic              aw_have_q, aw_have_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              w_have_q, w_have_d;
    logic              awready_q, awready_d, wready_q, wready_d;
    logic              bvalid_q, bvalid_d, arready_q, arready_d;
    logic              rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;
    slic_led_t         led_q, led_d;

    // write and read channels; write commits once address and data both held
    always_comb
    begin
        logic w1c;
        w1c       = 1'b0;
        ctrl_d    = ctrl_q;
        cfg_d     = cfg_q;
        awaddr_d  = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (bvalid_q && i_bready)
            bvalid_d = 1'b0;
        if (i_awvalid && awready_q)
        begin
            awaddr_d  = i_awaddr;
            aw_have_d = 1'b1;
        end
        if (i_wvalid && wready_q)
        begin
            wdata_d  = i_wdata;
            wstrb_d  = i_wstrb;
            w_have_d = 1'b1;
        end
        if (aw_have_q && w_have_q && !bvalid_q)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = addr_ok(awaddr_q) ? `SLIC_RESP_OK : `SLIC_RESP_ERR;
            unique case (awaddr_q)
                ADDR_W'(`SLIC_OFF_CTRL): ctrl_d = slic_ctrl_t'(merge(ctrl_q, wdata_q, wstrb_q));
                ADDR_W'(`SLIC_OFF_CFG):  cfg_d  = slic_cfg_t'(merge(cfg_q, wdata_q, wstrb_q));
                ADDR_W'(`SLIC_OFF_STAT): w1c    = wstrb_q[0] & wdata_q[0];
                default:                 w1c    = 1'b0;
            endcase
            ctrl_d.rsvd = '0;
            cfg_d.rsvd  = '0;
        end
        // the logged fault is sticky; a new event beats the clear
        fault_d = (fault_q & ~w1c) | i_fault_evt;
        if (rvalid_q && i_rready)
            rvalid_d = 1'b0;
        if (i_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = addr_ok(i_araddr) ? `SLIC_RESP_OK : `SLIC_RESP_ERR;
            unique case (i_araddr)
                ADDR_W'(`SLIC_OFF_CTRL): rdata_d = ctrl_q;
                ADDR_W'(`SLIC_OFF_CFG):  rdata_d = cfg_q;
                ADDR_W'(`SLIC_OFF_STAT): rdata_d = {20'h00000, act_s2_q, fault_q};
                ADDR_W'(`SLIC_OFF_LEDS): rdata_d = {14'h0000, o_beep, led_q};
                default:                 rdata_d = 32'h0000_0000;
            endcase
        end
        // readies are registered: one item of each kind in flight
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ctrl_q    <= slic_ctrl_t'(`SLIC_CTRL_RST);
            cfg_q     <= slic_cfg_t'(`SLIC_CFG_RST);
            fault_q   <= 1'b0;
            awaddr_q  <= '0;
            aw_have_q <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SLIC_RESP_OK;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `SLIC_RESP_OK;
        end
        else if (i_ce)
        begin
            ctrl_q    <= ctrl_d;
            cfg_q     <= cfg_d;
            fault_q   <= fault_d;
            awaddr_q  <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            w_have_q  <= w_have_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign o_awready = awready_q;
    assign o_wready  = wready_q;
    assign o_arready = arready_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // LED and beeper decode

    logic beep_q, beep_d;

    always_comb
    begin
        logic on;
        logic blink;
        logic sync_ph;
        on      = (ctrl_q.power == PWR_ON);
        blink   = (idx_q % (`SLIC_PULSE_TICKS * 6'h02)) < `SLIC_PULSE_TICKS;
        sync_ph = (idx_q % `SLIC_SYNC_PERIOD) < `SLIC_PULSE_TICKS;
        led_d   = '0;
        led_d.pwr_green = on || (ctrl_q.auto_power && ctrl_q.power == PWR_STANDBY
                                 && flash_code(idx_q, 3'h3));
        led_d.tx_yellow = act_s2_q.transfer;
        // boot states steady; update or fault flashes code 1
        if (ctrl_q.boot != BOOT_DONE)
            led_d.fault_red = 1'b1;
        else
            led_d.fault_red = (ctrl_q.fw_update || fault_q) && flash_code(idx_q, 3'h1);
        unique case (cfg_q.temp)
            TEMP_OVER_STBY: led_d.temp_red = flash_code(idx_q, 3'h3);
            TEMP_OVER_STOP: led_d.temp_red = 1'b1;
            TEMP_REACHED:   led_d.temp_red = flash_code(idx_q, 3'h2);
            TEMP_NORMAL:    led_d.temp_red = 1'b0;
        endcase
        beep_d = (cfg_q.temp == TEMP_REACHED) ? led_d.temp_red : (cfg_q.temp != TEMP_NORMAL);
        led_d.model_yellow = (ctrl_q.model == MODEL_RAM && flash_code(idx_q, 3'h1))
                          || (ctrl_q.model == MODEL_FLASH && flash_code(idx_q, 3'h3));
        // driver state, shown only while a model runs
        if (ctrl_q.model != MODEL_NONE)
            led_d.drv_green = flash_code(idx_q, ctrl_q.realtime_io_driver ? 3'h1 : 3'h3);
        // slave alternates half and full; slave wins if both set
        if (ctrl_q.sync_slave)
        begin
            led_d.sync_blue = sync_ph && (idx_q % (`SLIC_SYNC_PERIOD * 6'h02)
                                          < `SLIC_SYNC_HALF ? 1'b1 : pwm_q);
        end
        else if (ctrl_q.sync_master)
        begin
            led_d.sync_blue = sync_ph;
        end
        // interface group gated by the fully powered state
        if (on)
        begin
            // any of the four bus channels
            led_d.bus_yellow   = |{act_s2_q.can, act_s2_q.lin};
            led_d.probe_yellow = act_s2_q.probe;
            // port traffic in both port modes
            led_d.io_yellow    = act_s2_q.io;
            if (!cfg_q.io_fieldbus)
            begin
                // chain error steady, configuration at 1 Hz
                led_d.io_red = (cfg_q.chain == CHAIN_ERR)
                    || (cfg_q.chain == CHAIN_CONFIG
                        && (idx_q % (`SLIC_HZ1_TICKS * 6'h02)) < `SLIC_HZ1_TICKS);
            end
            else
            begin
                unique case (cfg_q.fb_state)
                    FB_PREOP:  led_d.io_red = blink;
                    FB_SAFEOP: led_d.io_red = idx_q < `SLIC_PULSE_TICKS;
                    FB_OP:     led_d.io_red = 1'b1;
                    FB_BOOT:   led_d.io_red = idx_q[0];
                    default:   led_d.io_red = 1'b0;
                endcase
            end
            // Ethernet traffic and speed, dark without link
            led_d.eth_t_yellow = act_s2_q.eth_act & act_s2_q.eth_link;
            led_d.eth_s_green  = act_s2_q.eth_link & cfg_q.eth_gig;
            led_d.eth_s_yellow = act_s2_q.eth_link & ~cfg_q.eth_gig;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            led_q  <= '0;
            beep_q <= 1'b0;
        end
        else if (i_ce)
        begin
            led_q  <= led_d;
            beep_q <= beep_d;
        end
    end

    assign o_led  = led_q;
    assign o_beep = beep_q;

endmodule : slic_top

//--- slic_top_bench.sv
// self-checking bench of the status indicator controller
`timescale 1ns/1ps
module slic_top_bench;
    import slic_pkg::*;
    localparam int L = $bits(slic_led_t);
    typedef struct {
        logic [11:0] ctrl;
        logic [9:0]  cfg;
        logic [10:0] act;
        int          sel;
        logic [7:0]  lit;
        logic [7:0]  fl;
    } slic_row_t;
    logic        i_clk_sys = 1'b0, i_resetn = 1'b1, i_ce = 1'b1, i_fault_evt = 1'b0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, clr = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00, lit_cnt, flash_cnt;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [3:0]  i_wstrb = 4'hF;
    logic [4:0]  sel = 5'h00;
    slic_act_t   i_act = '0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_beep;
    logic [1:0]  o_bresp, o_rresp;
    slic_led_t   o_led;
    int          error_cnt = 0, checked = 0, cyc = 0;
    // control, config, activity, lamp, lit cycles and flashes per 2 s frame
    slic_row_t rows [$] = '{
        '{12'h2, 10'h0, 11'h0, L, 8'hA0, 8'h0},
        '{12'h5, 10'h0, 11'h0, L, 8'h30, 8'h3},
        '{12'h2, 10'h0, 11'h400, L-1, 8'hA0, 8'h0},
        '{12'hA, 10'h0, 11'h0, L-2, 8'hA0, 8'h0},
        '{12'h12, 10'h0, 11'h0, L-2, 8'hA0, 8'h0},
        '{12'h22, 10'h0, 11'h0, L-2, 8'h10, 8'h1},
        '{12'h2, 10'h3, 11'h0, L-3, 8'h30, 8'h3},
        '{12'h2, 10'h2, 11'h0, L-3, 8'hA0, 8'h0},
        '{12'h2, 10'h1, 11'h0, L-3, 8'h20, 8'h2},
        '{12'h2, 10'h0, 11'h0, L-3, 8'h0, 8'h0},
        '{12'h42, 10'h0, 11'h0, L-4, 8'h10, 8'h1},
        '{12'h82, 10'h0, 11'h0, L-4, 8'h30, 8'h3},
        '{12'h142, 10'h0, 11'h0, L-5, 8'h10, 8'h1},
        '{12'h42, 10'h0, 11'h0, L-5, 8'h30, 8'h3},
        '{12'h202, 10'h0, 11'h0, L-6, 8'h30, 8'h3},
        '{12'h402, 10'h0, 11'h0, L-6, 8'h28, 8'hA},
        '{12'h2, 10'h0, 11'h100, L-7, 8'hA0, 8'h0},
        '{12'h2, 10'h0, 11'h40, L-7, 8'hA0, 8'h0},
        '{12'h1, 10'h0, 11'h100, L-7, 8'h0, 8'h0},
        '{12'h2, 10'h0, 11'h20, L-8, 8'hA0, 8'h0},
        '{12'h2, 10'h0, 11'h10, L-9, 8'hA0, 8'h0},
        '{12'h2, 10'h8, 11'h0, L-10, 8'hA0, 8'h0},
        '{12'h2, 10'h10, 11'h0, L-10, 8'h50, 8'h2},
        '{12'h2, 10'h4, 11'h0, L-10, 8'h0, 8'h0},
        '{12'h2, 10'h24, 11'h0, L-10, 8'h50, 8'h5},
        '{12'h2, 10'h44, 11'h0, L-10, 8'h10, 8'h1},
        '{12'h2, 10'h64, 11'h0, L-10, 8'hA0, 8'h0},
        '{12'h2, 10'h84, 11'h0, L-10, 8'h50, 8'h14},
        '{12'h2, 10'h4, 11'h10, L-9, 8'hA0, 8'h0},
        '{12'h2, 10'h0, 11'h5, L-12, 8'hA0, 8'h0},
        '{12'h2, 10'h100, 11'h1, L-14, 8'hA0, 8'h0},
        '{12'h2, 10'h0, 11'h1, L-16, 8'hA0, 8'h0},
        '{12'h2, 10'h1, 11'h0, 0, 8'h20, 8'h2},
        '{12'h2, 10'h2, 11'h0, 0, 8'hA0, 8'h0}
    };

    ////////////////////////////////////////////////////////////////////////////////
    // 40 ns clock; short tick keeps a 40-tick frame at 160 cycles
    always #20 i_clk_sys = ~i_clk_sys;
    slic_top #(.TICK_CYCLES(4)) dut (
        .i_clk_sys, .i_resetn, .i_ce, .i_act, .i_fault_evt, .i_awaddr, .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
        .i_rready, .o_led, .o_beep
    );
    slic_panel u_panel (.i_clk_sys, .i_clr(clr), .i_sel(sel), .i_led(o_led),
        .i_beep(o_beep), .o_on(lit_cnt), .o_rise(flash_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // write; bready only after bvalid so the slave must hold its answer
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clk_sys);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, d, 2'h3};
        do
        begin
            @(posedge i_clk_sys);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
        end
        while (o_bvalid !== 1'b1);
        i_bready <= 1'b1;
        @(posedge i_clk_sys);
        i_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(o_bresp));
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge i_clk_sys);
        {i_araddr, i_arvalid} <= {a, 1'b1};
        do
            @(posedge i_clk_sys);
        while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        while (o_rvalid !== 1'b1)
            @(posedge i_clk_sys);
        i_rready <= 1'b1;
        @(posedge i_clk_sys);
        i_rready <= 1'b0;
        chk("rdata", ed, o_rdata);
        chk("rresp", 32'(er), 32'(o_rresp));
    endtask : axr

    // settle allows two sync stages, output flop and register commit
    task automatic setup(input logic [11:0] c, input logic [9:0] f, input logic [10:0] a);
        axw(8'h00, 32'(c), 2'h0);
        axw(8'h04, 32'(f), 2'h0);
        i_act <= a;
        repeat (4) @(posedge i_clk_sys);
    endtask : setup

    // one full frame window gives exact counts whatever its phase
    task automatic look(input int s, input logic [7:0] el, input logic [7:0] ef);
        @(posedge i_clk_sys);
        {sel, clr} <= {5'(s), 1'b1};
        @(posedge i_clk_sys);
        clr <= 1'b0;
        repeat (160) @(posedge i_clk_sys);
        #1;
        chk("lit cycles", 32'(el), 32'(lit_cnt));
        chk("flashes", 32'(ef), 32'(flash_cnt));
    endtask : look

    // hang guard well above the expected run length
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    initial
    begin
        i_resetn <= 1'b0;
        repeat (12) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk("lamps after reset", 32'h0, 32'({o_led, o_beep}));
        axr(8'h0, 32'h0, 2'h0);
        axr(8'h4, 32'h0, 2'h0);
        foreach (rows[i])
        begin
            setup(rows[i].ctrl, rows[i].cfg, rows[i].act);
            look(rows[i].sel, rows[i].lit, rows[i].fl); // one per row
        end
        // reserved bits, unmapped place
        axw(8'h0, 32'hF5A6, 2'h0);
        axr(8'h0, 32'h5A6, 2'h0);
        axw(8'h10, 32'h1, 2'h2);
        axr(8'h10, 32'h0, 2'h2);
        // logged fault is sticky until cleared
        setup(12'h2, 10'h0, 11'h0);
        i_fault_evt <= 1'b1;
        @(posedge i_clk_sys);
        i_fault_evt <= 1'b0;
        look(L-2, 8'h10, 8'h1);
        axr(8'h8, 32'h1, 2'h0);
        axw(8'h8, 32'h1, 2'h0);
        look(L-2, 8'h0, 8'h0);
        // frozen clock enable ignores new activity, then a mid-run reset
        setup(12'h2, 10'h2, 11'h400);
        {i_ce, i_act} <= {1'b0, 11'h0};
        repeat (4) @(posedge i_clk_sys);
        chk("frozen lamp", 32'h1, 32'(o_led.tx_yellow));
        i_ce <= 1'b1;
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk("lamps in reset", 32'h0, 32'({o_led, o_beep}));
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        axr(8'h00, 32'h0, 2'h0);
        results();
    end
endmodule : slic_top_bench
